/* File: include/audio_dma_pkg.sv */
// Shared constants, field layouts and carrier types of the audio DMA index and status block.
package audio_dma_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int unsigned INDEX_W      = 5;
    localparam int unsigned LIST_ENTRIES = 32;
    localparam int unsigned ENTRY_BYTES  = 8;
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned STATUS_W     = 16;
    localparam int unsigned IO_ADDR_W    = 8;
    localparam int unsigned IO_DATA_W    = 32;
    localparam int unsigned IO_BE_W      = 4;
    localparam int unsigned SAMPLE_W     = 16;

    // ------------------------------------------------------------------
    // Register offsets (byte offsets from the channel's I/O base)
    // ------------------------------------------------------------------
    localparam logic [IO_ADDR_W-1:0] CUR_INDEX_OFS  = 8'h04;
    localparam logic [IO_ADDR_W-1:0] LAST_INDEX_OFS = 8'h05;
    localparam logic [IO_ADDR_W-1:0] STATUS_OFS     = 8'h06;
    localparam logic [IO_ADDR_W-1:0] DWORD_MASK     = 8'hFC;

    // Byte lanes of the doubleword at the current index offset.
    localparam int unsigned LANE_CUR_INDEX  = 0;
    localparam int unsigned LANE_LAST_INDEX = 1;
    localparam int unsigned LANE_STATUS_LO  = 2;
    localparam int unsigned LANE_STATUS_HI  = 3;

    // ------------------------------------------------------------------
    // Status fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned ST_HALTED      = 0;
    localparam int unsigned ST_AT_END      = 1;
    localparam int unsigned ST_FINAL_DONE  = 2;
    localparam int unsigned ST_BUFFER_DONE = 3;
    localparam int unsigned ST_FIFO_FAULT  = 4;

    localparam logic [INDEX_W-1:0]  INDEX_RESET  = 5'h00;
    localparam logic [INDEX_W-1:0]  INDEX_STEP   = 5'h01;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 16'h0001;
    localparam logic [IO_DATA_W-1:0] RDATA_ZERO  = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                 valid;
        logic                 write;
        logic [IO_ADDR_W-1:0] addr;
        logic [IO_BE_W-1:0]   be;
        logic [IO_DATA_W-1:0] wdata;
    } io_req_s;

    typedef struct packed {
        logic buffer_done;
        logic completion_notify_request;
        logic run;
        logic idle;
    } engine_ev_s;

endpackage

/* File: rtl/audio_dma_index_status.sv */
// Descriptor index tracking and status register of one audio bus-master DMA channel.
`timescale 1ns/1ps

// What this block does
// - Current index is a read-only 5-bit field; upper three bits read zero.
// - Current index steps by one whenever a descriptor finishes.
// - Current index wraps from 31 to 0, never saturates.
// - Last valid index is 5-bit read/write, upper bits zero, resets to zero.
// - One 32-bit read at offset 04h returns both indexes and status.
// - Byte reads of each index and a 16-bit status read also work.
// - Status is 16 bits, resets to 0001h, bits 15 to 5 reserved.
// - Status bit 4 sets on a FIFO fault.
// - Inbound overrun drops the arriving data and leaves FIFO pointers alone.
// - Outbound underrun keeps sending the last valid sample.
// - FIFO fault flag sets only while further valid buffers remain.
// - Status bit 3 sets when a buffer completes with notification requested.
// - Flags bits 4, 3, 2 clear only by writing one; zero leaves them.
// - List entries are 8 bytes each, at most 32, from aligned base.
// - Status bit 2 latches when the last valid buffer is done.
// - Status bit 0 reads one while halted: stopped and idle, or finished.
module audio_dma_index_status
    import audio_dma_pkg::*;
#(
    parameter bit          OUTBOUND = 1'b0,
    parameter int unsigned DATA_W   = audio_dma_pkg::SAMPLE_W
) (
    input  wire logic                                  clock,
    input  wire logic                                  reset,
    input  wire audio_dma_pkg::io_req_s                io_req,
    output logic                                       io_ack_q,
    output logic [audio_dma_pkg::IO_DATA_W-1:0]        io_rdata_q,
    input  wire audio_dma_pkg::engine_ev_s             engine_ev,
    output logic [audio_dma_pkg::INDEX_W-1:0]          current_descriptor_index_q,
    output logic [audio_dma_pkg::INDEX_W-1:0]          last_valid_descriptor_index_q,
    output logic                                       engine_halted_flag_q,
    input  wire logic                                  in_valid,
    input  wire logic [DATA_W-1:0]                     in_data,
    input  wire logic                                  fifo_full,
    output logic                                       fifo_push_q,
    output logic [DATA_W-1:0]                          fifo_push_data_q,
    input  wire logic                                  sample_req,
    input  wire logic                                  fifo_valid,
    input  wire logic [DATA_W-1:0]                     fifo_data,
    output logic                                       fifo_pop_q,
    output logic [DATA_W-1:0]                          sample_q
);
    import audio_dma_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic                 at_end_q;
    logic                 final_buffer_done_flag_q;
    logic                 buffer_done_flag_q;
    logic                 fifo_fault_flag_q;
    logic                 overrun_q;
    logic                 underrun_q;
    logic                 fault_event;
    logic                 sel_dword;
    logic                 wr_last_index;
    logic                 wr_status;
    logic                 clr_final;
    logic                 clr_buffer;
    logic                 clr_fault;
    logic                 done_at_last;
    logic [STATUS_W-1:0]  status_word;
    logic [IO_DATA_W-1:0] rdata_d;

    // ------------------------------------------------------------------
    // Data path guard
    // ------------------------------------------------------------------
    fifo_guard #(
        .DATA_W (DATA_W)
    ) u_guard (
        .clock            (clock),
        .reset            (reset),
        .in_valid         (in_valid),
        .in_data          (in_data),
        .fifo_full        (fifo_full),
        .fifo_push_q      (fifo_push_q),
        .fifo_push_data_q (fifo_push_data_q),
        .sample_req       (sample_req),
        .fifo_valid       (fifo_valid),
        .fifo_data        (fifo_data),
        .fifo_pop_q       (fifo_pop_q),
        .sample_q         (sample_q),
        .overrun_q        (overrun_q),
        .underrun_q       (underrun_q)
    );

    // Only the fault that belongs to this channel's direction counts.
    assign fault_event = OUTBOUND ? underrun_q : overrun_q;

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // The byte enables select lanes inside the one doubleword, so an access
    // that crosses into the next doubleword cannot be expressed here.
    always_comb
    begin
        sel_dword = 1'b0;
        if ((io_req.addr & DWORD_MASK) == CUR_INDEX_OFS)
        begin
            sel_dword = io_req.valid;
        end
        else
        begin
            sel_dword = 1'b0;
        end
    end

    assign wr_last_index = sel_dword && io_req.write && io_req.be[LANE_LAST_INDEX];
    assign wr_status     = sel_dword && io_req.write && io_req.be[LANE_STATUS_LO];

    // Write one to clear; a zero in the lane leaves the flag alone.
    assign clr_final  = wr_status && io_req.wdata[BYTE_W*LANE_STATUS_LO + ST_FINAL_DONE];
    assign clr_buffer = wr_status && io_req.wdata[BYTE_W*LANE_STATUS_LO + ST_BUFFER_DONE];
    assign clr_fault  = wr_status && io_req.wdata[BYTE_W*LANE_STATUS_LO + ST_FIFO_FAULT];

    assign done_at_last = engine_ev.buffer_done
                          && (current_descriptor_index_q == last_valid_descriptor_index_q);

    // ------------------------------------------------------------------
    // Current descriptor index
    // ------------------------------------------------------------------
    // A 5-bit counter wraps naturally; each count names one 8-byte entry.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            current_descriptor_index_q <= INDEX_RESET;
        end
        else if (engine_ev.buffer_done)
        begin
            current_descriptor_index_q <= current_descriptor_index_q + INDEX_STEP;
        end
    end

    // ------------------------------------------------------------------
    // Last valid descriptor index
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            last_valid_descriptor_index_q <= INDEX_RESET;
        end
        else if (wr_last_index)
        begin
            last_valid_descriptor_index_q <=
                io_req.wdata[BYTE_W*LANE_LAST_INDEX +: INDEX_W];
        end
    end

    // ------------------------------------------------------------------
    // End-of-list state
    // ------------------------------------------------------------------
    // Finishing the last valid buffer parks the channel here until software
    // writes the last valid index, whatever its value; a new index written in the same cycle wins.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            at_end_q <= 1'b0;
        end
        else if (wr_last_index)
        begin
            at_end_q <= 1'b0;
        end
        else if (done_at_last)
        begin
            at_end_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Sticky status flags
    // ------------------------------------------------------------------
    // Each set term comes last so an event in the clearing cycle survives.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            final_buffer_done_flag_q <= STATUS_RESET[ST_FINAL_DONE];
        end
        else
        begin
            if (clr_final)
            begin
                final_buffer_done_flag_q <= 1'b0;
            end
            if (done_at_last)
            begin
                final_buffer_done_flag_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            buffer_done_flag_q <= STATUS_RESET[ST_BUFFER_DONE];
        end
        else
        begin
            if (clr_buffer)
            begin
                buffer_done_flag_q <= 1'b0;
            end
            if (engine_ev.buffer_done && engine_ev.completion_notify_request)
            begin
                buffer_done_flag_q <= 1'b1;
            end
        end
    end

    // A starved or flooded FIFO after the list is exhausted is expected,
    // so it is not reported as a fault.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            fifo_fault_flag_q <= STATUS_RESET[ST_FIFO_FAULT];
        end
        else
        begin
            if (clr_fault)
            begin
                fifo_fault_flag_q <= 1'b0;
            end
            if (fault_event && !at_end_q)
            begin
                fifo_fault_flag_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Halted flag
    // ------------------------------------------------------------------
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            engine_halted_flag_q <= STATUS_RESET[ST_HALTED];
        end
        else
        begin
            engine_halted_flag_q <= (!engine_ev.run && engine_ev.idle) || at_end_q;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Reserved status bits and the upper index bits are constant zero and no
    // write path reaches them.
    always_comb
    begin
        status_word                = '0;
        status_word[ST_HALTED]     = engine_halted_flag_q;
        status_word[ST_AT_END]     = at_end_q;
        status_word[ST_FINAL_DONE] = final_buffer_done_flag_q;
        status_word[ST_BUFFER_DONE] = buffer_done_flag_q;
        status_word[ST_FIFO_FAULT] = fifo_fault_flag_q;
        rdata_d                    = RDATA_ZERO;
        if (sel_dword && !io_req.write)
        begin
            if (io_req.be[LANE_CUR_INDEX])
            begin
                rdata_d[BYTE_W*LANE_CUR_INDEX +: INDEX_W] = current_descriptor_index_q;
            end
            if (io_req.be[LANE_LAST_INDEX])
            begin
                rdata_d[BYTE_W*LANE_LAST_INDEX +: INDEX_W] = last_valid_descriptor_index_q;
            end
            if (io_req.be[LANE_STATUS_LO])
            begin
                rdata_d[BYTE_W*LANE_STATUS_LO +: BYTE_W] = status_word[BYTE_W-1:0];
            end
            if (io_req.be[LANE_STATUS_HI])
            begin
                rdata_d[BYTE_W*LANE_STATUS_HI +: BYTE_W] = status_word[STATUS_W-1:BYTE_W];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register port answer
    // ------------------------------------------------------------------
    // Every request is acknowledged, mapped or not, so software never hangs.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            io_ack_q   <= 1'b0;
            io_rdata_q <= RDATA_ZERO;
        end
        else
        begin
            io_ack_q   <= io_req.valid;
            io_rdata_q <= rdata_d;
        end
    end

endmodule

/* File: rtl/fifo_guard.sv */
// FIFO overrun and underrun guard for one audio DMA data path.
`timescale 1ns/1ps
module fifo_guard #(
    parameter int unsigned DATA_W = 16
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              in_valid,
    input  wire logic [DATA_W-1:0] in_data,
    input  wire logic              fifo_full,
    output logic                   fifo_push_q,
    output logic [DATA_W-1:0]      fifo_push_data_q,
    input  wire logic              sample_req,
    input  wire logic              fifo_valid,
    input  wire logic [DATA_W-1:0] fifo_data,
    output logic                   fifo_pop_q,
    output logic [DATA_W-1:0]      sample_q,
    output logic                   overrun_q,
    output logic                   underrun_q
);

    // ------------------------------------------------------------------
    // Inbound side
    // ------------------------------------------------------------------
    // A word that meets a full FIFO is dropped: no push, no pointer move.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            fifo_push_q      <= 1'b0;
            fifo_push_data_q <= '0;
            overrun_q        <= 1'b0;
        end
        else
        begin
            fifo_push_q <= in_valid && !fifo_full;
            overrun_q   <= in_valid && fifo_full;
            if (in_valid && !fifo_full)
            begin
                fifo_push_data_q <= in_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outbound side
    // ------------------------------------------------------------------
    // On underrun the held sample is simply not replaced, so it repeats.
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            fifo_pop_q <= 1'b0;
            sample_q   <= '0;
            underrun_q <= 1'b0;
        end
        else
        begin
            fifo_pop_q <= sample_req && fifo_valid;
            underrun_q <= sample_req && !fifo_valid;
            if (sample_req && fifo_valid)
            begin
                sample_q <= fifo_data;
            end
        end
    end

endmodule

/* File: sim/audio_dma_index_status_asserts.sv */
// Concurrent checks on the ports of the audio DMA index and status block.
`timescale 1ns/1ps
module audio_dma_index_status_asserts
    import audio_dma_pkg::*;
#(
    parameter bit          OUTBOUND = 1'b0,
    parameter int unsigned DATA_W   = 16
) (
    input wire logic                    clock,
    input wire logic                    reset,
    input wire audio_dma_pkg::io_req_s  io_req,
    input wire logic                    io_ack_q,
    input wire logic [31:0]             io_rdata_q,
    input wire audio_dma_pkg::engine_ev_s engine_ev,
    input wire logic [4:0]              current_descriptor_index_q,
    input wire logic [4:0]              last_valid_descriptor_index_q,
    input wire logic                    engine_halted_flag_q,
    input wire logic                    in_valid,
    input wire logic [DATA_W-1:0]       in_data,
    input wire logic                    fifo_full,
    input wire logic                    fifo_push_q,
    input wire logic [DATA_W-1:0]       fifo_push_data_q,
    input wire logic                    sample_req,
    input wire logic                    fifo_valid,
    input wire logic [DATA_W-1:0]       fifo_data,
    input wire logic                    fifo_pop_q,
    input wire logic [DATA_W-1:0]       sample_q
);
    logic io_hit;
    logic last_wr;
    logic rd_full;
    assign io_hit  = io_req.valid && ((io_req.addr & DWORD_MASK) == CUR_INDEX_OFS);
    assign last_wr = io_hit && io_req.write && io_req.be[LANE_LAST_INDEX];
    assign rd_full = io_hit && !io_req.write && (io_req.be == 4'hF);

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence last_done;
        engine_ev.buffer_done && !last_wr
            && (current_descriptor_index_q == last_valid_descriptor_index_q);
    endsequence

    chk_ack_timing: assert property (io_ack_q == $past(io_req.valid))
        else $error("ack not one cycle after request");
    chk_index_step: assert property (engine_ev.buffer_done |=>
        current_descriptor_index_q == $past(current_descriptor_index_q) + 5'h01)
        else $error("index did not step by one");
    chk_index_hold: assert property (!engine_ev.buffer_done |=>
        $stable(current_descriptor_index_q)) else $error("index moved without event");
    chk_last_write: assert property (last_wr |=>
        last_valid_descriptor_index_q == $past(io_req.wdata[12:8]))
        else $error("last index not written");
    chk_last_hold: assert property (!last_wr |=>
        $stable(last_valid_descriptor_index_q))
        else $error("last index changed without write");
    chk_dword_read: assert property (rd_full |=> io_rdata_q[15:0] ==
        {3'b000, $past(last_valid_descriptor_index_q), 3'b000, $past(current_descriptor_index_q)}
        && io_rdata_q[31:21] == 11'h000 && io_rdata_q[16] == $past(engine_halted_flag_q))
        else $error("doubleword read wrong");
    chk_unmapped_zero: assert property (io_req.valid && !io_hit |=> io_rdata_q == RDATA_ZERO)
        else $error("unmapped read not zero");
    chk_final_halts: assert property (last_done |=> ##1 engine_halted_flag_q)
        else $error("not halted after last buffer");
    chk_overrun_drop: assert property (in_valid && fifo_full |=> !fifo_push_q)
        else $error("word pushed into full fifo");
    chk_push_data: assert property (in_valid && !fifo_full |=>
        fifo_push_q && fifo_push_data_q == $past(in_data)) else $error("word not pushed");
    chk_underrun_hold: assert property (sample_req && !fifo_valid |=>
        $stable(sample_q) && !fifo_pop_q) else $error("sample changed on underrun");
    chk_sample_pop: assert property (sample_req && fifo_valid |=>
        fifo_pop_q && sample_q == $past(fifo_data)) else $error("sample not taken");
endmodule

bind audio_dma_index_status audio_dma_index_status_asserts #(
    .OUTBOUND(OUTBOUND), .DATA_W(DATA_W)) u_audio_dma_index_status_asserts (
    .clock(clock), .reset(reset), .io_req(io_req), .io_ack_q(io_ack_q),
    .io_rdata_q(io_rdata_q), .engine_ev(engine_ev),
    .current_descriptor_index_q(current_descriptor_index_q),
    .last_valid_descriptor_index_q(last_valid_descriptor_index_q),
    .engine_halted_flag_q(engine_halted_flag_q), .in_valid(in_valid), .in_data(in_data),
    .fifo_full(fifo_full), .fifo_push_q(fifo_push_q), .fifo_push_data_q(fifo_push_data_q),
    .sample_req(sample_req), .fifo_valid(fifo_valid), .fifo_data(fifo_data),
    .fifo_pop_q(fifo_pop_q), .sample_q(sample_q));

/* File: sim/fifo_partner.sv */
// Behavioural FIFO that stands on the far side of the block's data path.
`timescale 1ns/1ps
module fifo_partner #(
    parameter int unsigned DATA_W = 16,
    parameter int unsigned DEPTH  = 4
) (
    input  wire logic              clock,
    input  wire logic              reset,
    input  wire logic              push,
    input  wire logic [DATA_W-1:0] push_data,
    input  wire logic              pop,
    output logic                   full,
    output logic                   valid,
    output logic [DATA_W-1:0]      data
);
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DATA_W-1:0] last_q;
    int unsigned       wr_q;
    int unsigned       rd_q;
    int unsigned       count_q;

    // An empty FIFO shows the inverse of its last word, so a stale sample cannot pass.
    assign full  = (count_q == DEPTH);
    assign valid = (count_q != 0);
    assign data  = valid ? mem_q[rd_q] : ~last_q;

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            wr_q <= 0;
            rd_q <= 0;
            count_q <= 0;
            last_q <= '0;
        end
        else
        begin
            if (push && !full)
            begin
                mem_q[wr_q] <= push_data;
                wr_q <= (wr_q + 1) % DEPTH;
            end
            if (pop && valid)
            begin
                last_q <= mem_q[rd_q];
                rd_q <= (rd_q + 1) % DEPTH;
            end
            count_q <= count_q + 32'(push && !full) - 32'(pop && valid);
        end
    end
endmodule

/* File: sim/testbench.sv */
// Self-checking testbench of the audio DMA index and status block.
`timescale 1ns/1ps
module testbench;
    import audio_dma_pkg::*;
    logic                 clock;
    logic                 reset;
    io_req_s              io_req;
    logic                 io_ack_q;
    logic [31:0]          io_rdata_q;
    engine_ev_s           engine_ev;
    logic [4:0]           cur_idx;
    logic [4:0]           last_idx;
    logic                 in_valid;
    logic [15:0]          in_data;
    logic                 fifo_full;
    logic                 push;
    logic [15:0]          push_data;
    logic                 sample_req;
    logic                 fifo_valid;
    logic [15:0]          fifo_data;
    logic                 pop;
    logic [15:0]          sample_q;
    int                   miscompares;
    int                   n_compared;
    int                   cycles;

    audio_dma_index_status u_audio_dma_index_status (
        .clock(clock), .reset(reset), .io_req(io_req), .io_ack_q(io_ack_q),
        .io_rdata_q(io_rdata_q), .engine_ev(engine_ev), .current_descriptor_index_q(cur_idx),
        .last_valid_descriptor_index_q(last_idx), .engine_halted_flag_q(), .in_valid(in_valid),
        .in_data(in_data), .fifo_full(fifo_full), .fifo_push_q(push),
        .fifo_push_data_q(push_data), .sample_req(sample_req), .fifo_valid(fifo_valid),
        .fifo_data(fifo_data), .fifo_pop_q(pop), .sample_q(sample_q));

    fifo_partner u_fifo_partner (
        .clock(clock), .reset(reset), .push(push), .push_data(push_data), .pop(pop),
        .full(fifo_full), .valid(fifo_valid), .data(fifo_data));

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic tally_and_finish;
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
        begin
            $display("bench passed");
        end
        else
        begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One access: request held for the taking edge, answer looked at in its one cycle.
    task automatic io(input logic w, input logic [7:0] a, input logic [3:0] m,
                      input logic [31:0] d);
        @(posedge clock);
        io_req <= '{valid: 1'b1, write: w, addr: a, be: m, wdata: d};
        @(posedge clock);
        io_req.valid <= 1'b0;
        #1;
        cmp({31'h0, io_ack_q}, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, input logic [3:0] m, input logic [31:0] exp);
        io(1'b0, a, m, 32'h0);
        cmp(io_rdata_q, exp);
    endtask

    task automatic ev(input logic notify);
        @(posedge clock);
        engine_ev.buffer_done <= 1'b1;
        engine_ev.completion_notify_request <= notify;
        @(posedge clock);
        engine_ev.buffer_done <= 1'b0;
        engine_ev.completion_notify_request <= 1'b0;
    endtask

    task automatic put(input logic [15:0] d);
        @(posedge clock);
        in_valid <= 1'b1;
        in_data <= d;
        @(posedge clock);
        in_valid <= 1'b0;
    endtask

    task automatic take(input logic [15:0] exp);
        @(posedge clock);
        sample_req <= 1'b1;
        @(posedge clock);
        sample_req <= 1'b0;
        #1;
        cmp({16'h0, sample_q}, {16'h0, exp});
    endtask

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            miscompares++;
            tally_and_finish;
        end
    end

    initial
    begin
        reset = 1'b1;
        io_req = '0;
        engine_ev = '{buffer_done: 1'b0, completion_notify_request: 1'b0, run: 1'b0, idle: 1'b1};
        in_valid = 1'b0;
        in_data = 16'h0000;
        sample_req = 1'b0;
        miscompares = 0;
        n_compared = 0;
        cycles = 0;
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        rd(8'h04, 4'hF, 32'h0001_0000);
        rd(8'h04, 4'h1, 32'h0000_0000);
        rd(8'h05, 4'h2, 32'h0000_0000);
        rd(8'h06, 4'hC, 32'h0001_0000);
        @(posedge clock);
        engine_ev.run <= 1'b1;
        engine_ev.idle <= 1'b0;
        rd(8'h06, 4'hC, 32'h0000_0000);
        io(1'b1, 8'h04, 4'hF, 32'hFFE3_FFFF);
        rd(8'h04, 4'hF, 32'h0000_1F00);
        ev(1'b1);
        rd(8'h04, 4'hF, 32'h0008_1F01);
        io(1'b1, 8'h06, 4'h4, 32'h0000_0000);
        rd(8'h04, 4'hF, 32'h0008_1F01);
        io(1'b1, 8'h06, 4'h4, 32'h0008_0000);
        rd(8'h04, 4'hF, 32'h0000_1F01);
        ev(1'b0);
        rd(8'h04, 4'hF, 32'h0000_1F02);
        repeat (29) ev(1'b0);
        rd(8'h04, 4'hF, 32'h0000_1F1F);
        for (int i = 0; i < 4; i++)
        begin
            put(16'hA5A0 + 16'(i));
        end
        put(16'h5A5A);
        repeat (3) @(posedge clock);
        rd(8'h04, 4'hF, 32'h0010_1F1F);
        io(1'b1, 8'h06, 4'h4, 32'h0010_0000);
        rd(8'h04, 4'hF, 32'h0000_1F1F);
        ev(1'b0);
        rd(8'h04, 4'hF, 32'h0007_1F00);
        put(16'h1234);
        repeat (3) @(posedge clock);
        rd(8'h06, 4'hC, 32'h0007_0000);
        io(1'b1, 8'h06, 4'h4, 32'h0004_0000);
        rd(8'h04, 4'hF, 32'h0003_1F00);
        io(1'b1, 8'h05, 4'h2, 32'h0000_0500);
        rd(8'h04, 4'hF, 32'h0000_0500);
        rd(8'h08, 4'hF, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            take(16'hA5A0 + 16'(i));
        end
        take(16'hA5A3);
        rd(8'h06, 4'hC, 32'h0000_0000);
        tally_and_finish;
    end
endmodule
